// ---- src/drmr_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drmr_regs.svh"

module drmr_mode_regs
    import drmr_pkg::*;
#(
    parameter logic [7:0] REV_ID_FIRST  = 8'hA5, // Arbitrary value.
    parameter logic [7:0] REV_ID_SECOND = 8'h5A, // Arbitrary value.
    parameter logic [3:0] DENSITY_CODE  = `DRMR_DENS_4GB,
    parameter logic [1:0] IO_WIDTH_CODE = `DRMR_WIDTH_X16
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RESET_N,
    input  wire logic       MRW_VALID,
    input  wire logic       MRR_VALID,
    input  wire logic [5:0] MR_ADDR,
    input  wire logic [7:0] MR_WDATA,
    input  wire logic       WRITE_SET_POINT_SELECT,
    input  wire logic       OPERATING_SET_POINT_SELECT,
    input  wire logic       CAL_PIN_TO_RESISTOR,
    input  wire logic       CAL_CMD,
    output logic      [7:0] RD_DQ,
    output logic            RD_VALID,
    output logic            CAL_START,
    output logic            CAL_RESET,
    output logic            DEFAULT_CAL,
    output logic      [2:0] DQ_TERM,
    output logic      [2:0] CA_TERM
);

    drmr_state_t st_q;
    drmr_state_t st_d;
    logic [7:0]  cfg_word;
    logic        term_wr;
    logic [5:0]  term_wdata;
    logic [5:0]  term_applied;
    logic        cal_reset_wr;
    logic        cal_ok;

    // The configuration word is fixed by the die; no write can reach it.
    always_comb begin
        cfg_word = '0;
        cfg_word[`DRMR_TYPE_MSB:`DRMR_TYPE_LSB]   = `DRMR_TYPE_S16N;
        cfg_word[`DRMR_DENS_MSB:`DRMR_DENS_LSB]   = DENSITY_CODE;
        cfg_word[`DRMR_WIDTH_MSB:`DRMR_WIDTH_LSB] = IO_WIDTH_CODE;
    end

    // Write decode: only the two write-only registers have any effect.
    assign term_wr      = MRW_VALID && (MR_ADDR == `DRMR_MA_TERMINATION);
    assign term_wdata   = {MR_WDATA[`DRMR_CA_TERM_MSB:`DRMR_CA_TERM_LSB],
                           MR_WDATA[`DRMR_DQ_TERM_MSB:`DRMR_DQ_TERM_LSB]};
    assign cal_reset_wr = MRW_VALID && (MR_ADDR == `DRMR_MA_CAL_RESET)
                          && MR_WDATA[`DRMR_CAL_RESET_BIT];
    // Calibration acts only once the strap is known and ties to the resistor.
    assign cal_ok       = (st_q.phase == DRMR_ST_RUN) && st_q.strap_rzq;

    // Next state: strap capture, calibration control and the read path.
    always_comb begin
        st_d           = st_q;
        st_d.cal_start = 1'b0;
        st_d.cal_reset = 1'b0;
        st_d.rd_valid  = MRR_VALID;
        case (st_q.phase)
            DRMR_ST_STRAP: begin
                // The strap is caught after reset release, never by the reset itself.
                st_d.strap_rzq   = CAL_PIN_TO_RESISTOR;
                st_d.default_cal = !CAL_PIN_TO_RESISTOR;
                st_d.phase       = DRMR_ST_RUN;
            end
            DRMR_ST_RUN: begin
                if (cal_ok && cal_reset_wr) begin
                    st_d.cal_reset   = 1'b1;
                    st_d.default_cal = 1'b1;
                end else if (cal_ok && CAL_CMD) begin
                    st_d.cal_start   = 1'b1;
                    st_d.default_cal = 1'b0;
                end
            end
            default: begin
                st_d.phase = DRMR_ST_STRAP;
            end
        endcase
        // Read mux; write-only and unmapped addresses answer zero.
        if (!MRR_VALID) begin
            st_d.rd_data = `DRMR_READ_ZERO;
        end else if (MR_ADDR == `DRMR_MA_REV_FIRST) begin
            st_d.rd_data = REV_ID_FIRST;
        end else if (MR_ADDR == `DRMR_MA_REV_SECOND) begin
            st_d.rd_data = REV_ID_SECOND;
        end else if (MR_ADDR == `DRMR_MA_TYPE_DENSITY) begin
            st_d.rd_data = cfg_word;
        end else begin
            st_d.rd_data = `DRMR_READ_ZERO;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '{phase: DRMR_ST_STRAP, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Dual set point termination storage; a reserved code is stored but applied as disabled.
    drmr_term_store #(
        .SETS (2)
    ) u_term (
        .clk     (CLK_SYS),
        .rst_n   (RESET_N),
        .wr_en   (term_wr),
        .wr_sel  (WRITE_SET_POINT_SELECT),
        .wr_data (term_wdata),
        .op_sel  (OPERATING_SET_POINT_SELECT),
        .applied (term_applied)
    );

    // Reserved codes fall back to no termination, the safe choice for the receiver.
    assign DQ_TERM = (term_applied[2:0] == `DRMR_TERM_RESERVED) ? `DRMR_TERM_DISABLED
                                                                : term_applied[2:0];
    assign CA_TERM = (term_applied[5:3] == `DRMR_TERM_RESERVED) ? `DRMR_TERM_DISABLED
                                                                : term_applied[5:3];
    assign RD_DQ       = st_q.rd_data;
    assign RD_VALID    = st_q.rd_valid;
    assign CAL_START   = st_q.cal_start;
    assign CAL_RESET   = st_q.cal_reset;
    assign DEFAULT_CAL = st_q.default_cal;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    // Read answers arrive one cycle after the request with the exact contents.
    chk_rev_first: assert property (
        MRR_VALID && MR_ADDR == `DRMR_MA_REV_FIRST |=> RD_VALID && RD_DQ == REV_ID_FIRST)
        else $error("first revision read wrong");
    chk_rev_second: assert property (
        MRR_VALID && MR_ADDR == `DRMR_MA_REV_SECOND |=> RD_VALID && RD_DQ == REV_ID_SECOND)
        else $error("second revision read wrong");
    chk_cfg_type: assert property (
        MRR_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY |=> RD_DQ[`DRMR_TYPE_MSB:`DRMR_TYPE_LSB] == `DRMR_TYPE_S16N)
        else $error("device type field wrong");
    chk_cfg_density: assert property (
        MRR_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY |=> RD_DQ[`DRMR_DENS_MSB:`DRMR_DENS_LSB] == DENSITY_CODE)
        else $error("density field wrong");
    chk_cfg_width: assert property (
        MRR_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY |=> RD_DQ[`DRMR_WIDTH_MSB:`DRMR_WIDTH_LSB] == IO_WIDTH_CODE)
        else $error("width field wrong");

    // Write-only places answer zero, and an idle port keeps its data lines low.
    // A zero answer is the only safe choice: the controller cannot tell it from real contents.
    chk_wo_zero: assert property (
        MRR_VALID && (MR_ADDR == `DRMR_MA_CAL_RESET || MR_ADDR == `DRMR_MA_TERMINATION)
        |=> RD_DQ == `DRMR_READ_ZERO)
        else $error("write-only register read not zero");
    chk_rd_idle: assert property (
        !MRR_VALID |=> !RD_VALID && RD_DQ == `DRMR_READ_ZERO)
        else $error("data lines not zero when idle");
    chk_rd_follow: assert property (
        RD_VALID |-> $past(MRR_VALID))
        else $error("read answer without a read request");

    // A write to the configuration word followed by a read must still show the fixed fields.
    chk_ro_stable: assert property (
        MRW_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY ##1 MRR_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY
        |=> RD_DQ == {IO_WIDTH_CODE, DENSITY_CODE, `DRMR_TYPE_S16N})
        else $error("read-only register changed by write");

    // Calibration pulses: each one answers exactly one accepted request of the cycle before.
    // Back to back reset writes are legal, so the reset check looks at one cycle only.
    chk_cal_reset: assert property (
        cal_ok && cal_reset_wr |=> CAL_RESET && DEFAULT_CAL)
        else $error("calibration reset not applied");
    chk_cal_pulse: assert property (
        CAL_RESET |-> $past(cal_ok && cal_reset_wr))
        else $error("calibration reset without a request");
    chk_cal_start: assert property (
        CAL_START |-> $past(cal_ok && CAL_CMD && !cal_reset_wr) && !DEFAULT_CAL)
        else $error("calibration start without a request");

    // The strap is caught at the first edge after reset and decides the calibration source.
    chk_strap_capture: assert property (
        st_q.phase == DRMR_ST_STRAP |=> DEFAULT_CAL == !$past(CAL_PIN_TO_RESISTOR))
        else $error("strap not captured after reset");
    chk_strap_gnd: assert property (
        st_q.phase == DRMR_ST_RUN && !st_q.strap_rzq |-> !CAL_START && !CAL_RESET && DEFAULT_CAL)
        else $error("grounded strap did not ignore calibration");

    // Reserved termination codes are never applied; legal codes pass straight through.
    // A stored reserved code cannot be read back, since the register is write-only.
    chk_dq_reserved: assert property (
        term_applied[2:0] == `DRMR_TERM_RESERVED |-> DQ_TERM == `DRMR_TERM_DISABLED)
        else $error("reserved DQ code applied");
    chk_dq_pass: assert property (
        term_applied[2:0] != `DRMR_TERM_RESERVED |-> DQ_TERM == term_applied[2:0])
        else $error("DQ termination not applied");
    chk_ca_reserved: assert property (
        term_applied[5:3] == `DRMR_TERM_RESERVED |-> CA_TERM == `DRMR_TERM_DISABLED)
        else $error("reserved CA code applied");
    chk_ca_pass: assert property (
        term_applied[5:3] != `DRMR_TERM_RESERVED |-> CA_TERM == term_applied[5:3])
        else $error("CA termination not applied");

    // Cover points for the main scenarios: both calibration pulses, a configuration read,
    // a set point 1 termination that reaches the pins, and a grounded strap in operation.
    cov_cal_reset: cover property (CAL_RESET);
    cov_cal_start: cover property (CAL_START);
    cov_cfg_read: cover property (MRR_VALID && MR_ADDR == `DRMR_MA_TYPE_DENSITY ##1 RD_VALID);
    cov_term_set1: cover property (term_wr && WRITE_SET_POINT_SELECT ##2 OPERATING_SET_POINT_SELECT
                                   && DQ_TERM != `DRMR_TERM_DISABLED);
    cov_strap_gnd: cover property (st_q.phase == DRMR_ST_RUN && !st_q.strap_rzq);

endmodule
`default_nettype wire

// ---- src/drmr_regs.svh ----
`ifndef DRMR_REGS_SVH
`define DRMR_REGS_SVH

// Mode register addresses.
`define DRMR_MA_REV_FIRST      6'h06
`define DRMR_MA_REV_SECOND     6'h07
`define DRMR_MA_TYPE_DENSITY   6'h08
`define DRMR_MA_VENDOR_TEST    6'h09
`define DRMR_MA_CAL_RESET      6'h0A
`define DRMR_MA_TERMINATION    6'h0B

// Field positions and codes.
`define DRMR_TYPE_LSB          0
`define DRMR_TYPE_MSB          1
`define DRMR_DENS_LSB          2
`define DRMR_DENS_MSB          5
`define DRMR_WIDTH_LSB         6
`define DRMR_WIDTH_MSB         7
`define DRMR_TYPE_S16N         2'h0
`define DRMR_DENS_4GB          4'h0
`define DRMR_WIDTH_X16         2'h0
`define DRMR_CAL_RESET_BIT     0
`define DRMR_DQ_TERM_LSB       0
`define DRMR_DQ_TERM_MSB       2
`define DRMR_CA_TERM_LSB       4
`define DRMR_CA_TERM_MSB       6
`define DRMR_TERM_DISABLED     3'h0
`define DRMR_TERM_RESERVED     3'h7
`define DRMR_READ_ZERO         8'h00

`endif

// ---- src/drmr_pkg.sv ----
`default_nettype none

package drmr_pkg;

    // Start-up phase: the calibration strap is caught once after reset.
    typedef enum logic [0:0] {
        DRMR_ST_STRAP,
        DRMR_ST_RUN
    } drmr_phase_t;

    // State of the register bank, apart from the termination copies.
    typedef struct packed {
        drmr_phase_t phase;
        logic        strap_rzq;
        logic        default_cal;
        logic        cal_start;
        logic        cal_reset;
        logic        rd_valid;
        logic [7:0]  rd_data;
    } drmr_state_t;

    // Two termination copies, one per set point, plus the applied copy.
    typedef struct packed {
        logic [1:0][5:0] copy;
        logic [5:0]      applied;
    } drmr_term_state_t;

endpackage

`default_nettype wire

// ---- src/drmr_term_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drmr_regs.svh"

module drmr_term_store
    import drmr_pkg::*;
#(
    parameter int SETS = 2
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic       wr_sel,
    input  wire logic [5:0] wr_data,
    input  wire logic       op_sel,
    output logic      [5:0] applied
);

    drmr_term_state_t st_q;
    drmr_term_state_t st_d;
    logic [SETS-1:0]  hit;

    // One write enable per set point copy.
    genvar g;
    generate
        for (g = 0; g < SETS; g = g + 1) begin : g_hit
            assign hit[g] = wr_en && (wr_sel == 1'(g));
        end
    endgenerate

    // Only the selected copy takes a write; the applied copy follows the operating set point.
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < SETS; i++) begin
            if (hit[i]) begin
                st_d.copy[i] = wr_data;
            end
        end
        st_d.applied = st_q.copy[op_sel];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign applied = st_q.applied;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_copy_written: assert property (hit[0] |=> st_q.copy[0] == $past(wr_data))
        else $error("selected copy did not take the write");
    chk_other_kept: assert property (wr_en && wr_sel |=> st_q.copy[0] == $past(st_q.copy[0]))
        else $error("inactive copy changed on write");
    chk_applied_sel: assert property (1'b1 |=> applied == $past(st_q.copy[op_sel]))
        else $error("applied copy does not follow operating set point");

endmodule
`default_nettype wire

// ---- bench/drmr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Controller side of the mode register port; every command launches on a falling edge.
module drmr_ctrl_model (
    input  wire logic       clk,
    output logic            mrw_valid,
    output logic            mrr_valid,
    output logic      [5:0] mr_addr,
    output logic      [7:0] mr_wdata,
    output logic            cal_cmd
);
    // Bus starts idle at time zero.
    initial begin
        mrw_valid = 1'b0;
        mrr_valid = 1'b0;
        mr_addr   = 6'h00;
        mr_wdata  = 8'h00;
        cal_cmd   = 1'b0;
    end

    // One write or read command; the vendor test register only ever gets zero.
    task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        mrw_valid <= w;
        mrr_valid <= !w;
        mr_addr   <= a;
        mr_wdata  <= (a == 6'h09) ? 8'h00 : (a == 6'h0A) ? (d & 8'h01) : d;
    endtask

    // Calibration command pulse.
    task automatic cal();
        @(negedge clk);
        cal_cmd <= 1'b1;
    endtask

    // Released lines flip so that a stale value can never be read as valid.
    task automatic idle();
        @(negedge clk);
        mrw_valid <= 1'b0;
        mrr_valid <= 1'b0;
        cal_cmd   <= 1'b0;
        mr_addr   <= ~mr_addr;
        mr_wdata  <= ~mr_wdata;
    endtask
endmodule

`default_nettype wire

// ---- bench/test_dram_id_zq_odt_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_dram_id_zq_odt_mode_regs;
    import drmr_pkg::*;
    localparam logic [7:0] REV1 = 8'h3C; // Arbitrary value.
    localparam logic [7:0] REV2 = 8'hC3; // Arbitrary value.
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        wsp     = 1'b0;
    logic        osp     = 1'b0;
    logic        strap   = 1'b1;
    logic        mrw_valid, mrr_valid, cal_cmd, rd_valid, cal_start, cal_reset, default_cal;
    logic  [5:0] mr_addr;
    logic  [7:0] mr_wdata, rd_dq, r;
    logic  [2:0] dq_term, ca_term;
    logic  [7:0] rdq[$];
    logic  [1:0] calq[$];
    logic [31:0] seed = 32'hC7F8;
    int          fails = 0;
    int          num_checks = 0;

    always #20 clk_sys = ~clk_sys;

    drmr_ctrl_model ctrl (.clk(clk_sys), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
                          .mr_wdata(mr_wdata), .cal_cmd(cal_cmd));

    // A 2Gb x8 device, so that both density and width fields carry nonzero codes.
    drmr_mode_regs #(.REV_ID_FIRST(REV1), .REV_ID_SECOND(REV2), .DENSITY_CODE(4'hC), .IO_WIDTH_CODE(2'h1)) uut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .MRW_VALID(mrw_valid), .MRR_VALID(mrr_valid), .MR_ADDR(mr_addr),
        .MR_WDATA(mr_wdata), .WRITE_SET_POINT_SELECT(wsp), .OPERATING_SET_POINT_SELECT(osp),
        .CAL_PIN_TO_RESISTOR(strap), .CAL_CMD(cal_cmd), .RD_DQ(rd_dq), .RD_VALID(rd_valid),
        .CAL_START(cal_start), .CAL_RESET(cal_reset), .DEFAULT_CAL(default_cal), .DQ_TERM(dq_term),
        .CA_TERM(ca_term));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Single comparison point for every value the bench checks, except the final check for notes left in the queues.
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        rdq.push_back(exp);
        ctrl.cmd(1'b0, a, 8'h00);
    endtask

    task automatic term(input logic [2:0] dq, input logic [2:0] ca);
        cmp8("dq_term", dq, {5'h00, dq_term});
        cmp8("ca_term", ca, {5'h00, ca_term});
    endtask

    task automatic do_reset(input logic s);
        reset_n = 1'b0;
        strap   = s;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watcher: every answer pulse consumes the oldest note; an unexpected pulse meets an empty queue.
    always @(negedge clk_sys) begin
        if (reset_n) begin
            if (rd_valid === 1'b1) cmp8("read", rdq.size() ? rdq.pop_front() : 8'hEE, rd_dq);
            else cmp8("idle read data", 8'h00, rd_dq);
            if (cal_start === 1'b1 || cal_reset === 1'b1)
                cmp8("cal pulse", calq.size() ? {6'h00, calq.pop_front()} : 8'hEE, {6'h00, cal_start, cal_reset});
        end
    end

    initial begin
        do_reset(1'b1);
        rd(6'h06, REV1);
        rd(6'h07, REV2);
        rd(6'h08, 8'h70);
        rd(6'h09, 8'h00);
        rd(6'h0A, 8'h00);
        rd(6'h0B, 8'h00);
        rd(6'h3F, 8'h00);
        // Random writes to read-only places must not stick.
        for (int a = 6; a <= 9; a++) ctrl.cmd(1'b1, a[5:0], rnd());
        rd(6'h06, REV1);
        ctrl.cmd(1'b1, 6'h08, rnd());
        rd(6'h08, 8'h70);
        ctrl.idle();
        // Every code on both fields, random reserved bits, set point 0.
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            ctrl.cmd(1'b1, 6'h0B, {r[0], 3'(7 - i), r[1], 3'(i)});
            ctrl.idle();
            repeat (2) @(negedge clk_sys);
            term((i == 7) ? 3'h0 : 3'(i), (i == 0) ? 3'h0 : 3'(7 - i));
        end
        // Rewrite the inactive copy, then switch the applied copy over and back.
        wsp <= 1'b1;
        ctrl.cmd(1'b1, 6'h0B, 8'h25);
        ctrl.idle();
        repeat (2) @(negedge clk_sys);
        term(3'h0, 3'h0);
        osp <= 1'b1;
        @(negedge clk_sys);
        term(3'h5, 3'h2);
        osp <= 1'b0;
        @(negedge clk_sys);
        term(3'h0, 3'h0);
        // Calibration with the resistor strap.
        cmp8("default_cal", 8'h00, {7'h00, default_cal});
        calq.push_back(2'b10);
        ctrl.cal();
        ctrl.idle();
        calq.push_back(2'b01);
        ctrl.cmd(1'b1, 6'h0A, 8'h01);
        ctrl.cmd(1'b1, 6'h0A, 8'h00);
        ctrl.idle();
        repeat (2) @(negedge clk_sys);
        cmp8("default_cal", 8'h01, {7'h00, default_cal});
        // A calibration start after the reset leaves default calibration again.
        calq.push_back(2'b10);
        ctrl.cal();
        ctrl.idle();
        @(negedge clk_sys);
        cmp8("default_cal", 8'h00, {7'h00, default_cal});
        // Grounded strap: both calibration paths fall silent.
        do_reset(1'b0);
        cmp8("default_cal", 8'h01, {7'h00, default_cal});
        ctrl.cal();
        ctrl.idle();
        ctrl.cmd(1'b1, 6'h0A, 8'h01);
        ctrl.idle();
        repeat (3) @(negedge clk_sys);
        cmp8("default_cal", 8'h01, {7'h00, default_cal});
        for (int k = 0; k < 20 && (rdq.size() || calq.size()); k++) @(negedge clk_sys);
        if (rdq.size() || calq.size()) fails++;
        conclude();
    end
endmodule

`default_nettype wire
